// ===== logic/ctf_pkg.sv
/*
 package of constants for the timing fault/status block.
 assumes a 20 MHz system clock and a classic wishbone register bus.
*/
// Operation
// - keep a sixteen-bit fault word made of four hex nibbles
// - nibble 0: flash, config, no-signal, dac range; nibble 1: polls, osc fail, pll
// - red indicator lit whenever any fault word bit is set
// - dac over-range when control dac reaches 55000 or 10000 while locked
// - no-signal timeout after one hour without signal while merit stays 9
// - config fault set when controller cannot configure the logic; fatal
// - flash write fault set when a parameter write fails verification
// - pll fault bit follows the oscillator synthesizer unlocked report
// - oscillator failure bit set on detected synthesizer failure; fatal
// - missing-polls bit set when host polling requests stop arriving
// - time figure of merit 6..9 by error below 100us, 1ms, 10ms, else 9
// - processor state codes 0, 1, 2, 4, 8 for acquire through locked
// - channel reported as 0..3 primary a/b, secondary a/b
// - pseudonoise offset 0..511 in units of 64 chips
// - gain control setting reported as eight-bit value
// - oscillator control dac reported as sixteen-bit word
// - frame error rate reported 0.000 to 1.000, in thousandths
// - capture utc timestamp of the most recent polling request
// - report utc to gps leap second count as integer
// - report tracking status locked or not locked
// - leap modes auto and user; user mode holds current and future values
`default_nettype none
package ctf_pkg;
   localparam logic [7:0]  ADR_FAULT    = 8'h00;
   localparam logic [7:0]  ADR_STATUS   = 8'h04;
   localparam logic [7:0]  ADR_DACS     = 8'h08;
   localparam logic [7:0]  ADR_FER      = 8'h0c;
   localparam logic [7:0]  ADR_LEAPCTL  = 8'h10;
   localparam logic [7:0]  ADR_STAMP_D  = 8'h14;
   localparam logic [7:0]  ADR_STAMP_T  = 8'h18;
   localparam logic [7:0]  ADR_STAMP_S  = 8'h1c;
   localparam logic [7:0]  ADR_STICKY   = 8'h20;
   localparam logic [15:0] DAC_HI_LIM   = 16'hd6d8;   // 55000
   localparam logic [15:0] DAC_LO_LIM   = 16'h2710;   // 10000
   localparam logic [3:0]  TIME_FIGURE_OF_MERIT_BEST    = 4'h6;
   localparam logic [3:0]  TIME_FIGURE_OF_MERIT_UNSYNC  = 4'h9;
   localparam logic [9:0]  FER_MAX      = 10'h3e8;    // 1000 thousandths
   localparam logic [3:0]  SPS_ACQ      = 4'h0;
   localparam logic [3:0]  SPS_DET      = 4'h1;
   localparam logic [3:0]  SPS_CODE     = 4'h2;
   localparam logic [3:0]  SPS_CARR     = 4'h4;
   localparam logic [3:0]  SPS_LOCK     = 4'h8;
   localparam int          FB_DAC       = 0;
   localparam int          FB_NOSIG     = 1;
   localparam int          FB_CFG       = 2;
   localparam int          FB_FLASH     = 3;
   localparam int          FB_PLL       = 4;
   localparam int          FB_OSC       = 5;
   localparam int          FB_POLL      = 6;
   localparam logic [15:0] FAULT_USED   = 16'h007f;
   localparam logic [31:0] FAULT_RESET  = 32'h0;
   localparam longint      CLK_HZ       = 20000000;
   localparam longint      NOSIG_S      = 3600;       // one hour
   localparam longint      POLL_S       = 16;
   localparam longint      NOSIG_CYC    = NOSIG_S * CLK_HZ;
   localparam longint      POLL_TO_CYC  = 2 * POLL_S * CLK_HZ;
endpackage
`default_nettype wire

// ===== logic/ctf_status.sv
/*
 timing engine status and fault summary, wishbone slave.
 assumes status inputs synchronous to sys_clk_i and a single bus master.
*/
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ctf_status
   import ctf_pkg::*;
#(
   parameter longint NOSIG_CYCLES = NOSIG_CYC,
   parameter longint POLL_TIMEOUT = POLL_TO_CYC
)(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   input  wire logic [3:0]  sp_state_i,
   input  wire logic [1:0]  channel_i,
   input  wire logic [8:0]  pseudonoise_offset_i,
   input  wire logic [7:0]  gain_control_setting_i,
   input  wire logic [15:0] oscillator_control_dac_i,
   input  wire logic [9:0]  frame_err_i,
   input  wire logic [1:0]  time_err_class_i,
   input  wire logic        ever_locked_i,
   input  wire logic        auto_leap_i,
   input  wire logic [7:0]  auto_leap_count_i,
   input  wire logic        cfg_fail_i,
   input  wire logic        flash_verify_fail_i,
   input  wire logic        pll_unlocked_i,
   input  wire logic        osc_failed_i,
   input  wire logic        poll_req_i,
   input  wire logic [15:0] utc_year_i,
   input  wire logic [8:0]  day_of_year_i,
   input  wire logic [16:0] utc_sec_of_day_i,
   input  wire logic [29:0] utc_subsec_ns_i,
   output logic             red_led_o,
   output logic             tracking_lock_status_o,
   output logic [3:0]       time_figure_of_merit_o,
   output logic [15:0]      fault_summary_word_o
);
   typedef struct packed {
      logic [31:0] dat;
      logic        ack;
      logic        err;
      logic        led;
      logic        lock;
      logic [3:0]  time_figure_of_merit;
      logic [15:0] flt;
      logic        cfg_st;
      logic        flash_st;
      logic        osc_st;
      logic [63:0] nosig_cnt;
      logic [63:0] poll_cnt;
      logic        leap_user;
      logic [7:0]  leap_cur;
      logic [7:0]  leap_fut;
      logic [15:0] st_year;
      logic [8:0]  st_doy;
      logic [16:0] st_sod;
      logic [29:0] st_ns;
   } ctf_state_t;

   ctf_state_t s_r;
   ctf_state_t s_nxt;

   function automatic logic [3:0] ctf_time_figure_of_merit_f(input logic [1:0] cls, input logic ever);
      ctf_time_figure_of_merit_f = ever ? (TIME_FIGURE_OF_MERIT_BEST + {2'h0, cls}) : TIME_FIGURE_OF_MERIT_UNSYNC;
   endfunction

   function automatic logic ctf_sps_legal_f(input logic [3:0] st);
      ctf_sps_legal_f = (st == SPS_ACQ) || (st == SPS_DET) || (st == SPS_CODE)
                        || (st == SPS_CARR) || (st == SPS_LOCK);
   endfunction

   logic        locked;
   logic        req;
   logic [15:0] fword;
   logic [3:0]  time_figure_of_merit_now;
   assign locked   = (sp_state_i == SPS_LOCK);
   assign req      = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;
   assign time_figure_of_merit_now = ctf_time_figure_of_merit_f(time_err_class_i, ever_locked_i);

   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.err = 1'b0;
      s_nxt.lock = locked;
      s_nxt.time_figure_of_merit = time_figure_of_merit_now;
      if (cfg_fail_i) begin
         s_nxt.cfg_st = 1'b1;
      end
      if (flash_verify_fail_i) begin
         s_nxt.flash_st = 1'b1;
      end
      if (osc_failed_i) begin
         s_nxt.osc_st = 1'b1;
      end
      if (!locked && time_figure_of_merit_now == TIME_FIGURE_OF_MERIT_UNSYNC) begin
         if (s_r.nosig_cnt < 64'(NOSIG_CYCLES)) begin
            s_nxt.nosig_cnt = s_r.nosig_cnt + 64'h1;
         end
      end else begin
         s_nxt.nosig_cnt = 64'h0;
      end
      if (poll_req_i) begin
         s_nxt.poll_cnt = 64'h0;
         s_nxt.st_year = utc_year_i;
         s_nxt.st_doy  = day_of_year_i;
         s_nxt.st_sod  = utc_sec_of_day_i;
         s_nxt.st_ns   = utc_subsec_ns_i;
      end else if (s_r.poll_cnt < 64'(POLL_TIMEOUT)) begin
         s_nxt.poll_cnt = s_r.poll_cnt + 64'h1;
      end
      fword = 16'h0;
      fword[FB_DAC]   = locked && (oscillator_control_dac_i >= DAC_HI_LIM
                        || oscillator_control_dac_i <= DAC_LO_LIM);
      fword[FB_NOSIG] = (s_r.nosig_cnt >= 64'(NOSIG_CYCLES));
      fword[FB_CFG]   = s_nxt.cfg_st;
      fword[FB_FLASH] = s_nxt.flash_st;
      fword[FB_PLL]   = pll_unlocked_i;
      fword[FB_OSC]   = s_nxt.osc_st;
      fword[FB_POLL]  = (s_r.poll_cnt >= 64'(POLL_TIMEOUT));
      s_nxt.flt = fword & FAULT_USED;
      s_nxt.led = |(fword & FAULT_USED);
      if (req) begin
         s_nxt.dat = 32'h0;
         case (wb_adr_i)
            ADR_FAULT: s_nxt.dat = {16'h0, s_r.flt};
            ADR_STATUS: s_nxt.dat = {4'h0, (s_r.leap_user ? s_r.leap_cur
                                     : auto_leap_count_i),
                                     pseudonoise_offset_i, channel_i,
                                     sp_state_i, s_r.time_figure_of_merit, s_r.lock};
            ADR_DACS: s_nxt.dat = {gain_control_setting_i,
                                   8'h0, oscillator_control_dac_i};
            ADR_FER: s_nxt.dat = {22'h0, (frame_err_i > FER_MAX)
                                  ? FER_MAX : frame_err_i};
            ADR_LEAPCTL: s_nxt.dat = {7'h0, auto_leap_i, s_r.leap_user, 7'h0,
                                      s_r.leap_fut, s_r.leap_cur};
            ADR_STAMP_D: s_nxt.dat = {7'h0, s_r.st_doy, s_r.st_year};
            ADR_STAMP_T: s_nxt.dat = {15'h0, s_r.st_sod};
            ADR_STAMP_S: s_nxt.dat = {2'h0, s_r.st_ns};
            ADR_STICKY: s_nxt.dat = {29'h0, s_r.osc_st, s_r.flash_st, s_r.cfg_st};
            default: s_nxt.dat = 32'h0;
         endcase
         case (wb_adr_i)
            ADR_FAULT, ADR_STATUS, ADR_DACS, ADR_FER,
            ADR_STAMP_D, ADR_STAMP_T, ADR_STAMP_S: begin
               s_nxt.ack = 1'b1;
            end
            ADR_LEAPCTL: begin
               s_nxt.ack = 1'b1;
               if (wb_we_i) begin
                  if (wb_sel_i[0]) s_nxt.leap_cur = wb_dat_i[7:0];
                  if (wb_sel_i[1]) s_nxt.leap_fut = wb_dat_i[15:8];
                  if (wb_sel_i[2]) s_nxt.leap_user = wb_dat_i[23];
               end
            end
            ADR_STICKY: begin
               s_nxt.ack = 1'b1;
               if (wb_we_i && wb_sel_i[0]) begin
                  // write one clears; a new event in the same cycle wins
                  s_nxt.cfg_st   = (s_r.cfg_st && !wb_dat_i[0]) || cfg_fail_i;
                  s_nxt.flash_st = (s_r.flash_st && !wb_dat_i[1]) || flash_verify_fail_i;
                  s_nxt.osc_st   = (s_r.osc_st && !wb_dat_i[2]) || osc_failed_i;
               end
            end
            default: begin
               s_nxt.err = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         s_r <= '0;
         s_r.time_figure_of_merit <= TIME_FIGURE_OF_MERIT_UNSYNC;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_dat_o               = s_r.dat;
   assign wb_ack_o               = s_r.ack;
   assign wb_err_o               = s_r.err;
   assign red_led_o              = s_r.led;
   assign tracking_lock_status_o = s_r.lock;
   assign time_figure_of_merit_o = s_r.time_figure_of_merit;
   assign fault_summary_word_o   = s_r.flt;

   a_led_follows_flt: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      red_led_o == (fault_summary_word_o != 16'h0))
      else $error("red led disagrees with fault word");
   a_unused_bits_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      fault_summary_word_o[15:7] == 9'h0)
      else $error("unused fault bits set");
   a_dac_range_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (sp_state_i == SPS_LOCK && oscillator_control_dac_i >= DAC_HI_LIM)
      |=> fault_summary_word_o[FB_DAC])
      else $error("dac over-range not flagged");
   a_pll_tracks: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      pll_unlocked_i |=> fault_summary_word_o[FB_PLL])
      else $error("pll fault not flagged");
   a_cfg_sticky: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      cfg_fail_i |=> fault_summary_word_o[FB_CFG] [*2])
      else $error("config fault not held");
   a_osc_fail_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      osc_failed_i |=> fault_summary_word_o[FB_OSC])
      else $error("oscillator failure not flagged");
   a_flash_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      flash_verify_fail_i |=> fault_summary_word_o[FB_FLASH])
      else $error("flash fault not flagged");
   a_poll_clears: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      poll_req_i |=> ##1 !fault_summary_word_o[FB_POLL])
      else $error("missing poll flag stuck after poll");
   a_time_figure_of_merit_range: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !ever_locked_i |=> time_figure_of_merit_o == TIME_FIGURE_OF_MERIT_UNSYNC)
      else $error("merit not 9 when never locked");
   a_lock_status: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (sp_state_i == SPS_LOCK) |=> tracking_lock_status_o)
      else $error("lock status missing");
   c_led_on: cover property (@(posedge sys_clk_i) disable iff (reset_i) $rose(red_led_o));
   c_poll_seen: cover property (@(posedge sys_clk_i) disable iff (reset_i) poll_req_i);
   c_bus_read: cover property (@(posedge sys_clk_i) disable iff (reset_i) wb_ack_o);
   c_sps_legal: cover property (@(posedge sys_clk_i) disable iff (reset_i)
      ctf_sps_legal_f(sp_state_i) && sp_state_i == SPS_LOCK);
endmodule // ctf_status
`default_nettype wire

// ===== tb/ctf_host_poll.sv
/*
 host timing daemon model: one poll pulse per period.
 assumes a synchronous reset and a period scaled down from 16 s.
*/
`timescale 1ns/1ps
`default_nettype none
module ctf_host_poll #(
   parameter int PERIOD = 10
)(
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   input  wire logic poll_en_i,
   output logic      poll_req_o
);
   int cnt_r;
   always @(posedge sys_clk_i) begin
      if (reset_i || !poll_en_i) begin
         cnt_r <= 0;
         poll_req_o <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
         poll_req_o <= (cnt_r == PERIOD - 1);
      end
   end
endmodule // ctf_host_poll
`default_nettype wire

// ===== tb/tb.sv
/*
 self-checking bench for ctf_status over classic wishbone.
 assumes ctf_host_poll supplies the poll pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ctf_pkg::*;
   logic        sys_clk_i = 1'b0, reset_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0, ever_locked_i = 1'b1, auto_leap_i = 1'b1, err, poll_en = 1'b1;
   logic        cfg_fail_i = 1'b0, flash_verify_fail_i = 1'b0, osc_failed_i = 1'b0;
   logic        pll_unlocked_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00, gain_control_setting_i = 8'hff, auto_leap_count_i = 8'h12;
   logic [3:0]  wb_sel_i = 4'h0, sp_state_i = SPS_LOCK;
   logic [31:0] wb_dat_i = 32'h0, rd;
   logic [1:0]  channel_i = 2'h2, time_err_class_i = 2'h0;
   logic [8:0]  pseudonoise_offset_i = 9'h1ff, day_of_year_i = 9'h05c;
   logic [15:0] oscillator_control_dac_i = 16'h8000, utc_year_i = 16'h07d1;
   logic [9:0]  frame_err_i = 10'h3ff;
   logic [16:0] utc_sec_of_day_i = 17'h0ab3e;
   logic [29:0] utc_subsec_ns_i = 30'h15e6b1ba;
   logic [15:0] dv [4] = '{16'hd6d8, 16'hd6d7, 16'h2710, 16'h2711};
   logic [3:0]  sv [5] = '{SPS_ACQ, SPS_DET, SPS_CODE, SPS_CARR, SPS_LOCK};
   wire logic [31:0] wb_dat_o;
   wire logic [15:0] fault_summary_word_o;
   wire logic [3:0]  time_figure_of_merit_o;
   wire logic        wb_ack_o, wb_err_o, red_led_o, tracking_lock_status_o, poll_req_i;
   int          fail_count = 0, check_count = 0;
   always #25 sys_clk_i = ~sys_clk_i;
   ctf_status #(.NOSIG_CYCLES(20), .POLL_TIMEOUT(30)) u_dut (.sys_clk_i, .reset_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
      .sp_state_i, .channel_i, .pseudonoise_offset_i, .gain_control_setting_i,
      .oscillator_control_dac_i, .frame_err_i, .time_err_class_i, .ever_locked_i, .auto_leap_i,
      .auto_leap_count_i, .cfg_fail_i, .flash_verify_fail_i, .pll_unlocked_i, .osc_failed_i,
      .poll_req_i, .utc_year_i, .day_of_year_i, .utc_sec_of_day_i, .utc_subsec_ns_i, .red_led_o,
      .tracking_lock_status_o, .time_figure_of_merit_o, .fault_summary_word_o);
   ctf_host_poll #(.PERIOD(10)) u_host (.sys_clk_i, .reset_i, .poll_en_i(poll_en),
      .poll_req_o(poll_req_i));
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      rd = wb_dat_o;
      err = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk("bus latency", 32'h2, n);
      @(posedge sys_clk_i);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0, 4'hf);
      chk(nm, e, rd);
   endtask
   initial begin
      step(16);
      chk("merit in reset", 32'h9, time_figure_of_merit_o);
      reset_i <= 1'b0;
      step(3);
      rdchk(ADR_FAULT, 32'h0, "idle fault word");
      chk("lock", 32'h1, tracking_lock_status_o);
      for (int i = 0; i < 4; i++) begin
         time_err_class_i <= i[1:0];
         step(3);
         chk("merit", 6 + i, time_figure_of_merit_o);
      end
      time_err_class_i <= 2'h0;
      ever_locked_i <= 1'b0;
      step(3);
      chk("merit never locked", 32'h9, time_figure_of_merit_o);
      ever_locked_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         oscillator_control_dac_i <= dv[i];
         step(3);
         chk("dac range bit", (i % 2 == 0) ? 32'h1 : 32'h0, fault_summary_word_o);
         chk("red led", (i % 2 == 0) ? 32'h1 : 32'h0, red_led_o);
      end
      oscillator_control_dac_i <= 16'hd6d8;
      sp_state_i <= SPS_CARR;
      step(3);
      chk("dac range unlocked", 32'h0, fault_summary_word_o);
      chk("lock", 32'h0, tracking_lock_status_o);
      oscillator_control_dac_i <= 16'h8000;
      for (int i = 0; i < 5; i++) begin
         sp_state_i <= sv[i];
         step(2);
         wb(1'b0, ADR_STATUS, 32'h0, 4'hf);
         chk("state field", sv[i], rd[8:5]);
      end
      wb(1'b1, ADR_LEAPCTL, 32'h00800e0d, 4'hf);
      wb(1'b0, ADR_LEAPCTL, 32'h0, 4'hf);
      chk("leap ctl", 32'h01800e0d, rd);
      rdchk(ADR_STATUS, {4'h0, 8'h0d, 9'h1ff, 2'h2, SPS_LOCK, TIME_FIGURE_OF_MERIT_BEST, 1'b1}, "status");
      wb(1'b1, ADR_LEAPCTL, 32'h0, 4'hf);
      rdchk(ADR_STATUS, {4'h0, 8'h12, 9'h1ff, 2'h2, SPS_LOCK, TIME_FIGURE_OF_MERIT_BEST, 1'b1}, "status");
      rdchk(ADR_DACS, 32'hff008000, "dacs");
      rdchk(ADR_FER, 32'h3e8, "fer saturated");
      frame_err_i <= 10'h001;
      rdchk(ADR_FER, 32'h1, "fer");
      wb(1'b0, 8'h24, 32'h0, 4'hf);
      chk("unmapped err", 32'h1, err);
      cfg_fail_i <= 1'b1;
      flash_verify_fail_i <= 1'b1;
      osc_failed_i <= 1'b1;
      step(1);
      cfg_fail_i <= 1'b0;
      flash_verify_fail_i <= 1'b0;
      osc_failed_i <= 1'b0;
      step(4);
      chk("sticky faults", 32'h2c, fault_summary_word_o);
      pll_unlocked_i <= 1'b1;
      step(3);
      chk("pll fault", 32'h3c, fault_summary_word_o);
      pll_unlocked_i <= 1'b0;
      step(3);
      chk("pll fault gone", 32'h2c, fault_summary_word_o);
      wb(1'b1, ADR_STICKY, 32'h7, 4'h1);
      step(2);
      chk("cleared word", 32'h0, fault_summary_word_o);
      chk("led off", 32'h0, red_led_o);
      poll_en <= 1'b0;
      sp_state_i <= SPS_ACQ;
      ever_locked_i <= 1'b0;
      pll_unlocked_i <= 1'b1;
      step(12);
      chk("early timeouts", 32'h10, fault_summary_word_o);
      step(33);
      chk("timeouts", 32'h52, fault_summary_word_o);
      rdchk(ADR_FAULT, 32'h52, "unused bits");
      utc_year_i <= 16'h07d2;
      day_of_year_i <= 9'h0a0;
      utc_sec_of_day_i <= 17'h10000;
      utc_subsec_ns_i <= 30'h00001234;
      poll_en <= 1'b1;
      step(1);
      for (int n = 0; n < 40 && poll_req_i !== 1'b1; n++) @(posedge sys_clk_i);
      utc_year_i <= 16'h0000;
      day_of_year_i <= 9'h000;
      utc_sec_of_day_i <= 17'h0;
      utc_subsec_ns_i <= 30'h0;
      step(2);
      chk("poll flag cleared", 32'h12, fault_summary_word_o);
      rdchk(ADR_STAMP_D, {7'h0, 9'h0a0, 16'h07d2}, "stamp date");
      rdchk(ADR_STAMP_T, 32'h00010000, "stamp time");
      rdchk(ADR_STAMP_S, 32'h00001234, "stamp subsec");
      test_done;
   end
   initial begin
      step(5000);
      fail_count++;
      test_done;
   end
endmodule // tb
`default_nettype wire
